// ==== src/lsr_mcr_defines.svh ====
// register offsets, field positions and reset values for line status / modem control
`ifndef LINE_CTRL_DEFINES_SVH
`define LINE_CTRL_DEFINES_SVH

`define OFF_LINE_STATUS    8'h00
`define OFF_MODEM_CONTROL  8'h04
`define OFF_RECV_HOLDING   8'h08
`define OFF_MODEM_STATUS   8'h0C
`define OFF_ENHANCED       8'h10
`define OFF_RECV_PUSH      8'h14
`define OFF_XMIT_STATE     8'h18

`define CTL_RESET          8'h00
`define ENH_RESET          8'h00
`define ENH_WREN_BIT       4
`define FIFO_DEPTH         64
`define PTR_W              6
`define CNT_W              7
`define PRESCALE_DIV       2'h3

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== src/lsr_mcr_pkg.sv ====
// types shared by the line status / modem control block
package line_ctrl_pkg;

  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } bus_word_t;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;

endpackage

// ==== src/uart_line_status_modem_control.sv ====
// line status reporting, receive store and modem control for one uart channel
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`include "lsr_mcr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - status bit 7 high while any stored character has parity, framing or break error.
// - status bit 6 high only when holding and shift registers are both empty.
// - status bit 5 high when transmit holding register is empty.
// - a line-low frame stores character 00 with break flag, bit 4 shows it.
// - status bit 3 shows framing flag of the head character.
// - status bit 2 shows parity flag of the head character.
// - status bit 1 set after receive overrun, zero otherwise.
// - status bit 0 high whenever receive store holds a character.
// - bits 4 to 2 come straight from head character flags, no own storage.
// - status read leaves read pointer; only holding read advances it.
// - control bit 7 selects undivided or divide-by-4 baud clock.
// - control bit 6 opens access to threshold and trigger registers.
// - control bit 5 enables resume-on-any-character flow control.
// - writes to control bits 7 to 5 need enhanced bit 4 set.
// - control bit 4 loops transmit to receive and bits 3:0 into status.
// - control bit 3 enables interrupt outputs and, outside loop-back, drives general output low.
// - control bit 2 enables the combined fifo ready register.
// - control bit 1 drives rts low unless loop-back is on or auto flow control owns it.
// - control bit 0 drives dtr low; in loop-back feeds data-set-ready.
module uart_line_status_modem_control (
  input  wire logic        clock,          // 20 MHz clock
  input  wire logic        rst_b,          // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write strobes
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [7:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  input  wire logic        xmitHoldEmpty,  // transmit holding empty
  input  wire logic        xmitShiftEmpty, // transmit shifter empty
  input  wire logic        txSerial,       // transmit serial from shifter
  input  wire logic        rxPin,          // receive serial pin
  input  wire logic        ctsPin_b,       // clear to send pin
  input  wire logic        dsrPin_b,       // data set ready pin
  input  wire logic        riPin_b,        // ring indicator pin
  input  wire logic        cdPin_b,        // carrier detect pin
  input  wire logic        autoRtsEn,      // auto rts enable
  input  wire logic        autoRtsLevel,   // rts level from flow control
  input  wire logic        intRequest,     // interrupt from priority logic
  output logic             rxSerial,       // receive serial to receiver
  output logic             txPin,          // transmit pin
  output logic             rts_b,          // rts pin
  output logic             dtr_b,          // dtr pin
  output logic             generalOut_b,   // general output pin, low when on
  output logic             intOut,         // interrupt output data
  output logic             intOut_oe_b,    // interrupt output enable, low drives
  output logic             baudClkDiv4,    // prescaler select
  output logic             thresholdAccess, // threshold/trigger access
  output logic             xonAnyEn,       // resume on any character
  output logic             fifoReadyEn,    // combined fifo ready enable
  output logic [3:0]       modemLines,     // status bits 7:4 (cd ri dsr cts)
  output logic             rxFlushed       // tied low, store is never cleared
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_q <= 5'h1F;
      pinSync_q <= 5'h1F;
    end else begin
      pinMeta_q <= {rxPin, ctsPin_b, dsrPin_b, riPin_b, cdPin_b};
      pinSync_q <= pinMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] modemControl_q;
  logic [7:0] enhanced_q;
  logic       overrun_q;
  line_ctrl_pkg::rx_entry_t rxMem [`FIFO_DEPTH];
  logic [`PTR_W-1:0] rdPtr_q;
  logic [`PTR_W-1:0] wrPtr_q;
  logic [`CNT_W-1:0] count_q;
  logic [`CNT_W-1:0] errCount_q;

  function automatic logic entryErr(input line_ctrl_pkg::rx_entry_t e);
    entryErr = e.brk | e.frm | e.par;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write
  // ----------------------------------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wrFire;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign wrFire        = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  function automatic logic knownAddr(input logic [7:0] a);
    knownAddr = (a == `OFF_LINE_STATUS) || (a == `OFF_MODEM_CONTROL) || (a == `OFF_RECV_HOLDING) ||
                (a == `OFF_MODEM_STATUS) || (a == `OFF_ENHANCED) || (a == `OFF_RECV_PUSH) ||
                (a == `OFF_XMIT_STATE);
  endfunction

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= knownAddr(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wrCtl;
  logic wrEnh;
  logic wrPush;
  assign wrCtl  = wrFire && (awAddr_q == `OFF_MODEM_CONTROL) && wStrb_q[0];
  assign wrEnh  = wrFire && (awAddr_q == `OFF_ENHANCED) && wStrb_q[0];
  assign wrPush = wrFire && (awAddr_q == `OFF_RECV_PUSH) && wStrb_q[1];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      modemControl_q <= `CTL_RESET;
    end else if (wrCtl) begin
      modemControl_q[4:0] <= wData_q[4:0];
      if (enhanced_q[`ENH_WREN_BIT]) begin
        modemControl_q[7:5] <= wData_q[7:5];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enhanced_q <= `ENH_RESET;
    end else if (wrEnh) begin
      enhanced_q <= wData_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read
  // ----------------------------------------------------------------
  logic rdFire;
  logic rdSts;
  logic rdHld;
  logic [7:0] lineStatus;
  line_ctrl_pkg::rx_entry_t head;

  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign rdSts  = rdFire && (s_axi_araddr == `OFF_LINE_STATUS);
  assign rdHld  = rdFire && (s_axi_araddr == `OFF_RECV_HOLDING) && (count_q != '0);
  assign head   = rxMem[rdPtr_q];

  always_comb begin
    lineStatus    = 8'h00;
    lineStatus[7] = (errCount_q != '0);
    lineStatus[6] = xmitHoldEmpty && xmitShiftEmpty;
    lineStatus[5] = xmitHoldEmpty;
    if (count_q != '0) begin
      lineStatus[4] = head.brk;
      lineStatus[3] = head.frm;
      lineStatus[2] = head.par;
    end
    lineStatus[1] = overrun_q;
    lineStatus[0] = (count_q != '0);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= knownAddr(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFF_LINE_STATUS:   s_axi_rdata <= {24'h000000, lineStatus};
        `OFF_MODEM_CONTROL: s_axi_rdata <= {24'h000000, modemControl_q};
        `OFF_RECV_HOLDING:  s_axi_rdata <= {24'h000000, (count_q != '0) ? head.data : 8'h00};
        `OFF_MODEM_STATUS:  s_axi_rdata <= {24'h000000, modemLines, 4'h0};
        `OFF_ENHANCED:      s_axi_rdata <= {24'h000000, enhanced_q};
        `OFF_XMIT_STATE:    s_axi_rdata <= {25'h0000000, count_q};
        default:            s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive store
  // ----------------------------------------------------------------
  // push word: [7:0] data, [8] parity, [9] framing, [10] break
  logic pushOk;
  logic popOk;
  line_ctrl_pkg::rx_entry_t pushEntry;
  assign pushOk = wrPush && (count_q != `CNT_W'(`FIFO_DEPTH));
  assign popOk  = rdHld;
  always_comb begin
    pushEntry.brk  = wData_q[10];
    pushEntry.frm  = wData_q[9];
    pushEntry.par  = wData_q[8];
    pushEntry.data = wData_q[10] ? 8'h00 : wData_q[7:0];
  end

  always_ff @(posedge clock) begin
    if (pushOk) begin
      rxMem[wrPtr_q] <= pushEntry;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      count_q    <= '0;
      errCount_q <= '0;
    end else begin
      if (pushOk) begin
        wrPtr_q <= wrPtr_q + `PTR_W'(1);
      end
      if (popOk) begin
        rdPtr_q <= rdPtr_q + `PTR_W'(1);
      end
      count_q <= count_q + `CNT_W'(pushOk) - `CNT_W'(popOk);
      errCount_q <= errCount_q + `CNT_W'(pushOk && entryErr(pushEntry))
                    - `CNT_W'(popOk && entryErr(head));
    end
  end

  // overrun: set wins over read clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overrun_q <= 1'b0;
    end else if (wrPush && !pushOk) begin
      overrun_q <= 1'b1;
    end else if (rdSts) begin
      overrun_q <= 1'b0;
    end
  end

  assign rxFlushed = 1'b0;

  // ----------------------------------------------------------------
  // modem control outputs
  // ----------------------------------------------------------------
  logic loopOn;
  assign loopOn          = modemControl_q[4];
  assign baudClkDiv4     = modemControl_q[7];
  assign thresholdAccess = modemControl_q[6];
  assign xonAnyEn        = modemControl_q[5];
  assign fifoReadyEn     = modemControl_q[2];
  assign rxSerial        = loopOn ? txSerial : pinSync_q[4];
  assign txPin           = loopOn ? 1'b1 : txSerial;
  assign generalOut_b    = loopOn ? 1'b1 : !modemControl_q[3];
  assign intOut          = intRequest;
  assign intOut_oe_b     = !modemControl_q[3];
  assign rts_b = loopOn ? 1'b1 : (autoRtsEn ? autoRtsLevel : !modemControl_q[1]);
  assign dtr_b = loopOn ? 1'b1 : !modemControl_q[0];
  // cd, ri, dsr, cts
  assign modemLines = loopOn ?
    {modemControl_q[3], modemControl_q[2], modemControl_q[0], modemControl_q[1]} :
    {!pinSync_q[0], !pinSync_q[1], !pinSync_q[2], !pinSync_q[3]};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  guard_bits_a: assert property (wrCtl && !enhanced_q[`ENH_WREN_BIT] |=>
    modemControl_q[7:5] == $past(modemControl_q[7:5])) else $error("protected bits changed");
  sts_ptr_a: assert property (rdSts |=> rdPtr_q == $past(rdPtr_q)) else $error("status read moved pointer");
  hld_pop_a: assert property (rdHld |=> rdPtr_q == $past(rdPtr_q) + `PTR_W'(1)) else $error("pop missing");
  data_ready_a: assert property (lineStatus[0] == (count_q != '0)) else $error("data ready wrong");
  err_sum_a: assert property (pushOk && entryErr(pushEntry) |=> lineStatus[7]) else $error("error summary low");
  temt_a: assert property (lineStatus[6] |-> xmitHoldEmpty && xmitShiftEmpty) else $error("empty wrong");
  overrun_set_a: assert property (wrPush && !pushOk |=> lineStatus[1]) else $error("overrun not set");
  overrun_clr_a: assert property (rdSts && !wrPush |=> !overrun_q) else $error("overrun not cleared");
  loop_rx_a: assert property (loopOn |-> rxSerial == txSerial && dtr_b) else $error("loop wrong");
  int_oe_a: assert property (!modemControl_q[3] |-> intOut_oe_b) else $error("int enabled");
  break_zero_a: assert property (pushOk && pushEntry.brk |-> pushEntry.data == 8'h00) else $error("break data");

  // ----------------------------------------------------------------
  // read path and pin mapping checks
  // ----------------------------------------------------------------
  hold_empty_a: assert property (lineStatus[5] == xmitHoldEmpty)
    else $error("holding empty bit wrong");
  err_clear_a: assert property (count_q == '0 |-> !lineStatus[7])
    else $error("error summary with empty store");
  err_count_a: assert property (errCount_q <= count_q)
    else $error("more errors than characters");
  head_flags_a: assert property (rdSts && count_q != '0 |=>
    s_axi_rdata[4:2] == $past({head.brk, head.frm, head.par}))
    else $error("head flags not on status read");
  rhr_data_a: assert property (rdHld |=> s_axi_rdata[7:0] == $past(head.data))
    else $error("holding read data wrong");
  count_max_a: assert property (count_q <= `CNT_W'(`FIFO_DEPTH))
    else $error("store count above depth");
  overrun_hold_a: assert property (!wrPush && !rdSts |=> overrun_q == $past(overrun_q))
    else $error("overrun changed unprompted");
  upper_bits_a: assert property (wrCtl && enhanced_q[`ENH_WREN_BIT] |=>
    {baudClkDiv4, thresholdAccess, xonAnyEn} == $past(wData_q[7:5]))
    else $error("clock, access or xon bits not written");
  fifo_rdy_a: assert property (wrCtl |=> fifoReadyEn == $past(wData_q[2]))
    else $error("fifo ready enable not written");
  gen_out_a: assert property (!loopOn |-> generalOut_b == !modemControl_q[3])
    else $error("general output wrong");
  int_drive_a: assert property (modemControl_q[3] |-> !intOut_oe_b && intOut == intRequest)
    else $error("interrupt output not driven");
  rts_manual_a: assert property (!loopOn && !autoRtsEn |-> rts_b == !modemControl_q[1])
    else $error("rts not from control bit");
  rts_auto_a: assert property (!loopOn && autoRtsEn |-> rts_b == autoRtsLevel)
    else $error("rts not from flow control");
  dtr_drive_a: assert property (!loopOn |-> dtr_b == !modemControl_q[0])
    else $error("dtr not from control bit");
  loop_status_a: assert property (loopOn |->
    modemLines[3] == modemControl_q[3] && modemLines[1] == modemControl_q[0])
    else $error("loop status lines wrong");

  cov_overrun_c: cover property (wrPush && !pushOk);
  cov_loop_c: cover property (wrCtl && wData_q[4]);
  cov_err_pop_c: cover property (popOk && entryErr(head));
  cov_guard_c: cover property (wrCtl && enhanced_q[`ENH_WREN_BIT]);
  cov_head_brk_c: cover property (rdSts && head.brk && count_q != '0);

endmodule

`default_nettype wire

// ==== tb/modem_model.sv ====
// modem partner model on the serial control lines
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  input  wire logic rts_b,     // request to send from uart
  input  wire logic dtr_b,     // terminal ready from uart
  input  wire logic txPin,     // serial data from uart
  input  wire logic ringOn,    // bench asks for ring
  input  wire logic carrierOn, // bench asks for carrier
  output logic      ctsPin_b,  // clear to send
  output logic      dsrPin_b,  // data set ready
  output logic      riPin_b,   // ring indicator
  output logic      cdPin_b,   // carrier detect
  output logic      rxPin      // serial data toward uart
);
  // set ready follows terminal ready, clear to send follows request
  assign dsrPin_b = dtr_b;
  assign ctsPin_b = rts_b;
  assign riPin_b  = ~ringOn;
  assign cdPin_b  = ~carrierOn;
  // remote echo, line idles high like the transmitter
  assign rxPin    = txPin;
endmodule
`default_nettype wire

// ==== tb/uart_line_status_modem_control_tb.sv ====
// self-checking bench for line status and modem control
`include "lsr_mcr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_line_status_modem_control_tb;
  logic        clock, rst_b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, lines;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        holdE, shiftE, txSer, rxPin, cts_b, dsr_b, ri_b, cd_b, arEn, arLvl, intReq, ringOn, carrierOn;
  logic        rxSer, txPin, rts_b, dtr_b, gop_b, intOut, intOe_b, div4, lvlAcc, xonAny, frdy, flushed;
  int          err_count, cmp_count;

  uart_line_status_modem_control DUT (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .xmitHoldEmpty(holdE), .xmitShiftEmpty(shiftE), .txSerial(txSer), .rxPin(rxPin), .ctsPin_b(cts_b),
    .dsrPin_b(dsr_b), .riPin_b(ri_b), .cdPin_b(cd_b), .autoRtsEn(arEn), .autoRtsLevel(arLvl),
    .intRequest(intReq), .rxSerial(rxSer), .txPin(txPin), .rts_b(rts_b), .dtr_b(dtr_b),
    .generalOut_b(gop_b), .intOut(intOut), .intOut_oe_b(intOe_b), .baudClkDiv4(div4),
    .thresholdAccess(lvlAcc), .xonAnyEn(xonAny), .fifoReadyEn(frdy), .modemLines(lines),
    .rxFlushed(flushed));

  modem_model peer (.rts_b(rts_b), .dtr_b(dtr_b), .txPin(txPin), .ringOn(ringOn), .carrierOn(carrierOn),
    .ctsPin_b(cts_b), .dsrPin_b(dsr_b), .riPin_b(ri_b), .cdPin_b(cd_b), .rxPin(rxPin));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // reporting and bus cycles
  // ----------------------------------------
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic timed_out();
    err_count++;
    $display("unexpected at %0t: bus wait ran out", $time);
    stop_test();
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    int   n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      ta = pa && awready === 1'b1;
      tw = pw && wready === 1'b1;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      n++;
    end while ((pa || pw) && n < 50);
    if (pa || pw) timed_out();
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1) timed_out();
    rs = bresp;
    @(posedge clock);
    bready <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (arready !== 1'b1 && n < 50);
    if (arready !== 1'b1) timed_out();
    @(posedge clock);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1) timed_out();
    d = rdata;
    r = rresp;
    @(posedge clock);
    rready <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    bus_read(`OFF_MODEM_CONTROL, rd, rs);
    check(rd[7:0], `CTL_RESET, "control after reset");
    bus_read(`OFF_LINE_STATUS, rd, rs);
    check(rd[7:0] & 8'h9F, 8'h00, "status after reset");
    bus_read(8'h20, rd, rs);
    check(rd, 32'h0000_0000, "unmapped read data");
    check(rs, `RESP_SLVERR, "unmapped read response");
    bus_write(8'h20, 32'h0000_00FF);
    check(rs, `RESP_SLVERR, "unmapped write response");
    bus_write(`OFF_ENHANCED, 32'h0000_0000);
    check(rs, `RESP_OKAY, "mapped write response");
    check(flushed, 1'b0, "no flush pulse");
    $display("test reset done");
  endtask

  task automatic test_xmit();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      holdE <= c[1];
      shiftE <= c[0];
      bus_read(`OFF_LINE_STATUS, rd, rs);
      check(rd[6], c[1] & c[0], "transmitter empty");
      check(rd[5], c[1], "holding empty");
    end
    $display("test xmit done");
  endtask

  task automatic test_errors();
    logic [31:0] push [4] = '{32'h0000_0033, 32'h0000_0141, 32'h0000_0242, 32'h0000_0455};
    logic [7:0]  stat [4] = '{8'h81, 8'h85, 8'h89, 8'h91};
    logic [7:0]  dat [4]  = '{8'h33, 8'h41, 8'h42, 8'h00};
    foreach (push[i]) bus_write(`OFF_RECV_PUSH, push[i]);
    foreach (stat[i]) begin
      bus_read(`OFF_LINE_STATUS, rd, rs);
      check(rd[7:0] & 8'h9D, stat[i], "head flags");
      bus_read(`OFF_LINE_STATUS, rd, rs);
      check(rd[7:0] & 8'h9D, stat[i], "second status read");
      bus_read(`OFF_RECV_HOLDING, rd, rs);
      check(rd[7:0], dat[i], "character");
    end
    bus_read(`OFF_LINE_STATUS, rd, rs);
    check(rd[7:0] & 8'h9D, 8'h00, "store drained");
    $display("test errors done");
  endtask

  task automatic test_overrun();
    for (int i = 0; i < `FIFO_DEPTH; i++) bus_write(`OFF_RECV_PUSH, i);
    bus_read(`OFF_LINE_STATUS, rd, rs);
    check(rd[1], 1'b0, "full, no overrun");
    bus_write(`OFF_RECV_PUSH, 32'h0000_00AA);
    bus_read(`OFF_LINE_STATUS, rd, rs);
    check(rd[1], 1'b1, "overrun set");
    bus_read(`OFF_LINE_STATUS, rd, rs);
    check(rd[1], 1'b0, "overrun cleared");
    for (int i = 0; i < `FIFO_DEPTH; i++) begin
      bus_read(`OFF_RECV_HOLDING, rd, rs);
      check(rd[7:0], i, "drain order");
    end
    bus_read(`OFF_LINE_STATUS, rd, rs);
    check(rd[0], 1'b0, "empty again");
    $display("test overrun done");
  endtask

  task automatic test_protect();
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_00E0);
    bus_read(`OFF_MODEM_CONTROL, rd, rs);
    check({rd[7:0], div4, lvlAcc, xonAny}, 11'h000, "locked write");
    bus_write(`OFF_ENHANCED, 32'h0000_0010);
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_00E0);
    check({div4, lvlAcc, xonAny}, 3'b111, "enhanced bits set");
    bus_write(`OFF_ENHANCED, 32'h0000_0000);
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_0000);
    bus_read(`OFF_MODEM_CONTROL, rd, rs);
    check(rd[7:0], 8'hE0, "bits kept");
    bus_write(`OFF_ENHANCED, 32'h0000_0010);
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_0000);
    check({div4, lvlAcc, xonAny}, 3'b000, "enhanced bits clear");
    $display("test protect done");
  endtask

  task automatic test_pins();
    intReq <= 1'b1;
    ringOn <= 1'b1;
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_000F);
    check({rts_b, dtr_b, gop_b, intOe_b, frdy, intOut}, 6'b000011, "pins on");
    repeat (4) @(posedge clock);
    check(lines, 4'h7, "modem lines");
    bus_read(`OFF_MODEM_STATUS, rd, rs);
    check(rd[7:4], 4'h7, "modem status");
    arEn <= 1'b1;
    arLvl <= 1'b1;
    @(negedge clock);
    check(rts_b, 1'b1, "auto flow owns rts");
    @(posedge clock);
    arEn <= 1'b0;
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_0000);
    check({rts_b, dtr_b, gop_b, intOe_b, frdy}, 5'b11110, "pins off");
    $display("test pins done");
  endtask

  task automatic test_loop();
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_001A);
    check({lines, txPin, rts_b, dtr_b}, 7'b1001111, "loop lines");
    txSer <= 1'b0;
    @(negedge clock);
    check({rxSer, txPin}, 2'b01, "serial looped");
    bus_read(`OFF_MODEM_STATUS, rd, rs);
    check(rd[7:4], 4'h9, "loop status");
    bus_write(`OFF_MODEM_CONTROL, 32'h0000_0000);
    repeat (3) @(posedge clock);
    check({rxSer, txPin}, 2'b00, "serial through pins");
    txSer <= 1'b1;
    $display("test loop done");
  endtask

  initial begin
    rst_b = 1'b0;
    err_count = 0;
    cmp_count = 0;
    {awvalid, wvalid, bready, arvalid, rready, arEn, arLvl, intReq, ringOn, carrierOn} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {holdE, shiftE, txSer} = 3'b111;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    test_reset();
    test_xmit();
    test_errors();
    test_overrun();
    test_protect();
    test_pins();
    test_loop();
    stop_test();
  end
endmodule
`default_nettype wire
